// [logic/sar_adc_pkg.sv]
// Shared constants for the SAR converter control and serial readout
package sar_adc_pkg;

  // Result word
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned CODE_LEVELS = 65536;

  // Control clock (internal oscillator)
  localparam int unsigned CLOCK_PERIOD_NS = 40;

  // Longest conversion time, rounded down to whole cycles
  localparam int unsigned CONV_TIME_MAX_NS   = 3000;
  localparam int unsigned CONV_MAX_CYCLES    = CONV_TIME_MAX_NS / CLOCK_PERIOD_NS;

  // Shortest time between conversions at full rate, rounded up
  localparam int unsigned SAMPLE_PERIOD_NS   = 4000;
  localparam int unsigned SAMPLE_MIN_CYCLES  = (SAMPLE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Cycles given to the capacitor DAC to settle before each bit decision
  localparam int unsigned TRIAL_CYCLES = 4;

  // Result buffer depth
  localparam int unsigned FIFO_DEPTH = 8;

  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [4:0]  INDEX_RESET  = 5'h00;
  localparam logic        OE_N_RESET   = 1'h1;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    st_acquire,
    st_trial,
    st_done
  } conv_state_e;

endpackage : sar_adc_pkg

// [logic/sar_adc_serial_readout.sv]
// SAR conversion sequencer, result buffer and serial shift-out with daisy chain
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Result FIFO
module result_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [PTR_W:0]   next_count;
  logic             push;
  logic             pop;
  assign in_ready  = (count != (PTR_W+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
      next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
    if (pop)
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
    if (push && !pop)
      next_count = count + (PTR_W+1)'(1);
    else if (pop && !push)
      next_count = count - (PTR_W+1)'(1);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; out_valid masks stale entries
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule : result_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: conversion control and serial readout
module sar_adc_serial_readout #(
  parameter int unsigned BITS       = sar_adc_pkg::RESULT_BITS,
  parameter int unsigned FIFO_DEPTH = sar_adc_pkg::FIFO_DEPTH
) (
  input  wire logic            clock,
  input  wire logic            srst,
  input  wire logic            sck,
  input  wire logic            convert_start,
  input  wire logic            chain_select,
  input  wire logic            enable_or_chain_input,
  input  wire logic            compare_above,
  input  wire logic            result_ready,
  output logic                 busy,
  output logic                 power_up,
  output logic                 acquiring,
  output logic      [BITS-1:0] cap_weighted_dac,
  output logic                 sdo,
  output logic                 sdo_oe_n,
  output logic      [BITS-1:0] result_data,
  output logic                 result_valid
);

  localparam int unsigned IDX_W   = $clog2(BITS + 1);
  localparam int unsigned TRIAL_W = $clog2(sar_adc_pkg::TRIAL_CYCLES + 1);
  localparam int unsigned BIT_W   = $clog2(BITS);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers on the control clock
  logic start_meta;
  logic start_sync;
  logic start_prev;
  logic chain_meta;
  logic chain_sync;
  logic enable_meta;
  logic enable_sync;
  logic convert_rise;

  always_ff @(posedge clock)
  begin
    start_meta  <= convert_start;
    start_sync  <= start_meta;
    start_prev  <= start_sync;
    chain_meta  <= chain_select;
    chain_sync  <= chain_meta;
    enable_meta <= enable_or_chain_input;
    enable_sync <= enable_meta;
  end
  assign convert_rise = start_sync & ~start_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer, run by the internal clock only
  sar_adc_pkg::conv_state_e state;
  sar_adc_pkg::conv_state_e next_state;
  logic [BITS-1:0]    code;
  logic [BITS-1:0]    next_code;
  logic [BIT_W-1:0]   bit_pos;
  logic [BIT_W-1:0]   next_bit_pos;
  logic [TRIAL_W-1:0] settle;
  logic [TRIAL_W-1:0] next_settle;
  logic [BITS-1:0]    hold;
  logic [BITS-1:0]    next_hold;
  logic               fifo_in_ready;
  logic [BITS-1:0]    trial_weight;

  assign trial_weight = BITS'(1) << bit_pos;

  always_comb
  begin
    next_state       = state;
    next_code        = code;
    next_bit_pos     = bit_pos;
    next_settle      = settle;
    next_hold        = hold;
    case (state)
      sar_adc_pkg::st_acquire:
      begin
        // Edges during a conversion never reach here, so they are dropped
        if (convert_rise)
        begin
          next_state       = sar_adc_pkg::st_trial;
          next_code        = '0;
          next_bit_pos     = BIT_W'(BITS - 1);
          next_settle      = '0;
        end
      end
      sar_adc_pkg::st_trial:
      begin
        if (settle == TRIAL_W'(sar_adc_pkg::TRIAL_CYCLES - 1))
        begin
          next_settle = '0;
          // Keep the trial bit when the sampled input stays above the DAC
          if (compare_above)
          begin
            next_code = code | trial_weight;
          end
          if (bit_pos == '0)
          begin
            next_state = sar_adc_pkg::st_done;
          end
          else
          begin
            next_bit_pos = bit_pos - BIT_W'(1);
          end
        end
        else
        begin
          next_settle = settle + TRIAL_W'(1);
        end
      end
      sar_adc_pkg::st_done:
      begin
        // A full buffer holds busy high; result_ready held high never stalls
        if (fifo_in_ready)
        begin
          next_hold  = code;
          next_state = sar_adc_pkg::st_acquire;
        end
      end
      default:
      begin
        next_state = sar_adc_pkg::st_acquire;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state       <= sar_adc_pkg::st_acquire;
      code        <= sar_adc_pkg::RESULT_RESET;
      bit_pos     <= '0;
      settle      <= '0;
      hold        <= sar_adc_pkg::RESULT_RESET;
    end
    else
    begin
      state       <= next_state;
      code        <= next_code;
      bit_pos     <= next_bit_pos;
      settle      <= next_settle;
      hold        <= next_hold;
    end
  end

  // Sixteen trials of TRIAL_CYCLES plus one done cycle fit the conversion time limit
  assign busy             = (state != sar_adc_pkg::st_acquire);
  assign power_up         = busy;
  assign acquiring        = ~busy;
  assign cap_weighted_dac = (state == sar_adc_pkg::st_trial) ? (code | trial_weight) : code;

  //////////////////////////////////////////////////////////////////////////////
  // Parallel result stream through the buffer
  result_fifo #(
    .WIDTH (BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_data   (code),
    .in_valid  (state == sar_adc_pkg::st_done),
    .in_ready  (fifo_in_ready),
    .out_data  (result_data),
    .out_valid (result_valid),
    .out_ready (result_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Output enable and frame clear on the control clock
  logic oe_n;
  logic next_oe_n;
  logic frame_clear;
  logic next_frame_clear;

  always_comb
  begin
    // Chain mode drives the output continuously
    next_oe_n        = chain_sync ? 1'b0 : enable_sync;
    // Holding the link counter clear through a conversion restarts the frame
    next_frame_clear = (next_state != sar_adc_pkg::st_acquire);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      oe_n        <= sar_adc_pkg::OE_N_RESET;
      frame_clear <= 1'b1;
    end
    else
    begin
      oe_n        <= next_oe_n;
      frame_clear <= next_frame_clear;
    end
  end

  assign sdo_oe_n = oe_n;

  //////////////////////////////////////////////////////////////////////////////
  // Serial link, clocked by sck only
  logic             link_chain_meta;
  logic             link_chain;
  logic [IDX_W-1:0] bit_index;
  logic [IDX_W-1:0] next_bit_index;
  logic [BITS-1:0]  chain_buf;
  logic [BITS-1:0]  next_chain_buf;

  always_ff @(posedge sck)
  begin
    link_chain_meta <= chain_select;
    link_chain      <= link_chain_meta;
  end

  always_comb
  begin
    next_bit_index = (bit_index == IDX_W'(BITS)) ? bit_index : bit_index + IDX_W'(1);
    // Upstream bits trail our word by exactly BITS edges
    next_chain_buf = {chain_buf[BITS-2:0], enable_or_chain_input};
  end

  // frame_clear is a register; sck may be stopped while it acts
  always_ff @(posedge sck or posedge frame_clear)
  begin
    if (frame_clear)
    begin
      bit_index <= sar_adc_pkg::INDEX_RESET[IDX_W-1:0];
      chain_buf <= '0;
    end
    else
    begin
      bit_index <= next_bit_index;
      chain_buf <= next_chain_buf;
    end
  end

  // hold is quasi-static across the link: it changes only while frame_clear is high
  assign sdo = (bit_index < IDX_W'(BITS)) ? hold[BIT_W'(BITS - 1) - bit_index[BIT_W-1:0]]
                                          : (link_chain ? chain_buf[BITS-1] : 1'b0);

endmodule : sar_adc_serial_readout

// [sim/analog_front_model.sv]
// Sample-and-hold and comparator standing in for the analog input
`timescale 1ns/1ps
module analog_front_model (
  input  wire logic        clock,
  input  wire logic        acquiring,
  input  wire logic [15:0] level,
  input  wire logic [15:0] cap_weighted_dac,
  output logic             compare_above
);
  logic [15:0] held;
  // Tracks the input while acquiring, frozen through the conversion
  always_ff @(posedge clock)
    if (acquiring)
      held <= level;
  // Level is already the ideal code, so the result must equal it
  assign compare_above = held >= cap_weighted_dac;
endmodule : analog_front_model

// [sim/sar_adc_serial_readout_properties.sv]
// Port-level checks for the converter control and readout
`timescale 1ns/1ps
module sar_adc_checker #(
  parameter int unsigned BITS = 16
) (
  input wire logic            clock,
  input wire logic            srst,
  input wire logic            sck,
  input wire logic            convert_start,
  input wire logic            chain_select,
  input wire logic            enable_or_chain_input,
  input wire logic            compare_above,
  input wire logic            result_ready,
  input wire logic            busy,
  input wire logic            power_up,
  input wire logic            acquiring,
  input wire logic [BITS-1:0] cap_weighted_dac,
  input wire logic            sdo,
  input wire logic            sdo_oe_n,
  input wire logic [BITS-1:0] result_data,
  input wire logic            result_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  same_power_a: assert property (power_up == busy)
    else $error("power_up differs from busy");
  start_response_a: assert property ($rose(convert_start) && !busy |-> ##[1:5] busy)
    else $error("convert edge did not start a conversion");
  busy_length_a: assert property ($rose(busy) |-> ##64 busy)
    else $error("conversion ended before all trials");
  first_trial_a: assert property ($rose(busy) |-> cap_weighted_dac == {1'b1, {(BITS-1){1'b0}}})
    else $error("first trial is not the half-scale weight");
  result_push_a: assert property ($fell(busy) |-> result_valid)
    else $error("no result offered when busy fell");
  stream_hold_a: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result stream changed while stalled");
  chain_drive_a: assert property (chain_select [*5] |-> !sdo_oe_n)
    else $error("chain mode does not drive sdo");
  output_release_a: assert property ((!chain_select && enable_or_chain_input) [*5] |-> sdo_oe_n)
    else $error("sdo driven while disabled");
  output_enable_a: assert property ((!chain_select && !enable_or_chain_input) [*5] |-> !sdo_oe_n)
    else $error("sdo not driven while enabled");
endmodule : sar_adc_checker

bind sar_adc_serial_readout sar_adc_checker #(.BITS(BITS)) checker_u (
  .clock, .srst, .sck, .convert_start, .chain_select, .enable_or_chain_input, .compare_above,
  .result_ready, .busy, .power_up, .acquiring, .cap_weighted_dac, .sdo, .sdo_oe_n, .result_data, .result_valid
);

// [sim/sar_adc_serial_readout_test.sv]
// Self-checking bench for the converter control and serial readout
`timescale 1ns/1ps
module sar_adc_serial_readout_test;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        sck = 1'b0;
  logic        convert_start = 1'b0;
  logic        chain_select = 1'b0;
  logic        enable_or_chain_input = 1'b0;
  logic        compare_above;
  logic        result_ready = 1'b1;
  logic        busy;
  logic        power_up;
  logic        acquiring;
  logic [15:0] cap_weighted_dac;
  logic        sdo;
  logic        sdo_oe_n;
  logic [15:0] result_data;
  logic        result_valid;
  logic [15:0] level = 16'h0000;
  logic [31:0] got;
  logic [15:0] vals [5] = '{16'ha5c3, 16'h0000, 16'hffff, 16'h0001, 16'h8000};
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n;

  always #20 clock = ~clock;

  sar_adc_serial_readout dut_u (
    .clock, .srst, .sck, .convert_start, .chain_select, .enable_or_chain_input, .compare_above,
    .result_ready, .busy, .power_up, .acquiring, .cap_weighted_dac, .sdo, .sdo_oe_n, .result_data, .result_valid
  );
  analog_front_model front_u (.clock, .acquiring, .level, .cap_weighted_dac, .compare_above);

  task check(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
    cmp_count++;
    if (got_v !== exp_v)
    begin
      n_errors++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got_v, exp_v);
    end
  endtask : check

  // Poke pulses the pin in mid-conversion; n ends as the busy length, capped at 200
  task convert(input logic [15:0] v, input bit poke);
    @(negedge clock);
    level = v;
    convert_start = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    check(n inside {[3:4]}, 1, "start delay");
    n = 0;
    while (busy === 1'b1 && n < 200)
    begin
      @(negedge clock);
      n++;
      if (poke)
        convert_start = (n < 10 || n > 20);
    end
    convert_start = 1'b0;
  endtask : convert

  // Link clock runs only inside the frame, at 6 ns, phase offset from the control clock
  task shift(input int bits, input logic [31:0] sdi);
    got = '0;
    @(negedge clock);
    #7;
    for (int i = bits - 1; i >= 0; i--)
    begin
      got[i] = sdo;
      if (chain_select)
        enable_or_chain_input = sdi[i];
      #3 sck = 1'b1;
      #3 sck = 1'b0;
    end
  endtask : shift

  task summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (16) @(negedge clock);
    srst = 1'b0;
    foreach (vals[i])
    begin
      convert(vals[i], i == 4);
      check(n, 65, "busy cycles");
      check(n + 4 <= sar_adc_pkg::CONV_MAX_CYCLES, 1, "conversion time");
      check(result_valid, 1, "stream valid");
      check(result_data, vals[i], "stream word");
      shift(16, 0);
      check(got[15:0], vals[i], "serial word");
      check({busy, power_up, acquiring, sdo_oe_n}, 4'h2, "idle and driving");
    end
    enable_or_chain_input = 1'b1;
    repeat (5) @(negedge clock);
    check(sdo_oe_n, 1, "output released");
    chain_select = 1'b1;
    repeat (5) @(negedge clock);
    check(sdo_oe_n, 0, "chain drive");
    convert(16'h1234, 0);
    shift(32, 32'hbeef0000);
    check(got, 32'h1234beef, "chain word");
    @(negedge clock);
    chain_select = 1'b0;
    enable_or_chain_input = 1'b0;
    // Stall the sink: eight results fill the buffer, the ninth holds busy high
    result_ready = 1'b0;
    for (int i = 1; i <= 9; i++)
      convert(16'(i), 0);
    check(n, 200, "full buffer stall");
    result_ready = 1'b1;
    for (int i = 1; i <= 9; i++)
    begin
      n = 0;
      while (result_valid !== 1'b1 && n < 10)
      begin
        @(negedge clock);
        n++;
      end
      check(result_data, 16'(i), "drained word");
      @(negedge clock);
    end
    check({busy, result_valid}, 0, "drained empty");
    summarize();
  end

  initial
  begin
    #300000;
    n_errors++;
    $display("FAIL at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : sar_adc_serial_readout_test
